/* tb/btb_file_model.sv */
`default_nettype none
module btb_file_model (
  input wire logic i_sys_clk,
  input wire logic [6:0] i_f_addr,
  input wire logic i_f_we,
  input wire logic [7:0] i_f_wdata,
  output logic [7:0] o_f_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [128];
  initial begin
    for (int a = 0; a < 128; a++) mem_q[a] = 8'(a * 91) ^ 8'h3c;
  end
  // Read is same-cycle; a write lands at whatever address is shown at the edge
  assign o_f_rdata = mem_q[i_f_addr];
  always @(posedge i_sys_clk) begin
    if (i_f_we) mem_q[i_f_addr] <= i_f_wdata;
  end
endmodule
`default_nettype wire

/* tb/tb_bit_test_branch_call_exec.sv */
`default_nettype none
module tb_bit_test_branch_call_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_valid = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [13:0] i_instr = 14'h0;
  logic [14:0] i_pc = 15'h0;
  logic [7:0] i_wreg = 8'h0, i_pc_upper_latch = 8'h0, i_f_rdata;
  logic [6:0] o_f_addr;
  logic [7:0] o_f_wdata;
  logic [14:0] o_pc_next, o_stack_top;
  logic o_f_we, o_pc_load, o_push, o_flush, o_busy, o_watchdog_clr, o_prescaler_clr;
  logic o_timeout_flag_n, o_power_down_flag_n, o_status_we;
  logic [42:0] notes [$];
  logic [42:0] n;
  logic [7:0] mirror [128];
  int fail_count = 0, num_checks = 0;

  btb_exec i_dut (.i_sys_clk, .i_rst, .i_valid, .i_op, .i_instr, .i_pc, .i_wreg,
    .i_pc_upper_latch, .i_f_rdata, .o_f_addr, .o_f_we, .o_f_wdata, .o_pc_load,
    .o_pc_next, .o_push, .o_stack_top, .o_flush, .o_busy, .o_watchdog_clr,
    .o_prescaler_clr, .o_timeout_flag_n, .o_power_down_flag_n, .o_status_we);
  btb_file_model i_mem (.i_sys_clk, .i_f_addr(o_f_addr), .i_f_we(o_f_we),
    .i_f_wdata(o_f_wdata), .o_f_rdata(i_f_rdata));

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // Output watcher: every result pops the oldest note
  // ---------------------------------------------
  always @(posedge i_sys_clk) begin
    #1;
    if (!i_rst && (o_flush | o_f_we | o_watchdog_clr | o_push | o_pc_load | o_status_we)) begin
      if (notes.size() == 0) check("stray", 40'h0, 40'h1);
      else begin
        n = notes.pop_front();
        case (n[42:40])
          btb_pkg::OP_SKIP_SET: check("skip", n[39:0], {o_flush, o_status_we, o_push, o_pc_load});
          btb_pkg::OP_BIT_SET: check("bitset", n[39:0], {o_f_we, o_f_wdata, o_status_we});
          btb_pkg::OP_WDT_CLR: check("wdt", n[39:0], {o_watchdog_clr, o_prescaler_clr,
            o_timeout_flag_n, o_power_down_flag_n, o_status_we});
          default: check("pc", n[39:0], {o_flush, o_status_we, o_push,
            o_push ? o_stack_top : 15'h0, o_pc_load, o_pc_next});
        endcase
      end
    end
  end

  // ---------------------------------------------
  // Driver: one instruction, inputs held until its results stood
  // ---------------------------------------------
  task automatic run_op(input logic [2:0] op, input logic [13:0] ins, input logic [14:0] pc,
      input logic [7:0] w, input logic [7:0] lt);
    logic [7:0] rd;
    logic two;
    rd = mirror[ins[6:0]];
    two = 1'b1;
    @(posedge i_sys_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_instr <= ins;
    i_pc <= pc;
    i_wreg <= w;
    i_pc_upper_latch <= lt;
    case (op)
      btb_pkg::OP_SKIP_SET: begin
        two = rd[ins[9:7]];
        if (two) notes.push_back({op, 40'h8});
      end
      btb_pkg::OP_BRANCH_W: notes.push_back({op, 9'h004, 15'h0, 1'b1, 15'(pc + 15'h1 + w)});
      btb_pkg::OP_CALL:
        notes.push_back({op, 9'h005, 15'(pc + 15'h1), 1'b1, lt[6:3], ins[10:0]});
      btb_pkg::OP_CALL_W:
        notes.push_back({op, 9'h005, 15'(pc + 15'h1), 1'b1, lt[6:0], w});
      btb_pkg::OP_BIT_SET: begin
        two = 1'b0;
        mirror[ins[6:0]] = rd | (8'h01 << ins[9:7]);
        notes.push_back({op, 30'h0, 1'b1, mirror[ins[6:0]], 1'b0});
      end
      btb_pkg::OP_WDT_CLR: begin
        two = 1'b0;
        notes.push_back({op, 40'h1f});
      end
      default: two = 1'b0;
    endcase
    @(posedge i_sys_clk);
    // A bit set offered during the no-op cycle must be ignored
    i_valid <= two;
    i_op <= btb_pkg::OP_BIT_SET;
    #1;
    check("busy", 40'(two), 40'(o_busy));
    if (two) begin
      @(posedge i_sys_clk);
      i_valid <= 1'b0;
    end
  endtask

  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    for (int a = 0; a < 128; a++) mirror[a] = 8'(a * 91) ^ 8'h3c;
    void'($urandom(32'h49eb289e));
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    check("rst", 40'h3, {o_timeout_flag_n, o_power_down_flag_n});
    run_op(3'h0, 14'h3fff, 15'h7fff, 8'hff, 8'hff);
    run_op(3'h7, 14'h3fff, 15'h7fff, 8'hff, 8'hff);
    run_op(btb_pkg::OP_CALL, 14'h07ff, 15'h7fff, 8'h00, 8'hff);
    run_op(btb_pkg::OP_BRANCH_W, 14'h0, 15'h7ffe, 8'hff, 8'h00);
    for (int i = 0; i < 80; i++) begin
      run_op(3'(1 + $urandom % 6), 14'($urandom), 15'($urandom), 8'($urandom), 8'($urandom));
    end
    repeat (3) @(posedge i_sys_clk);
    check("left", 40'h0, 40'(notes.size()));
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/btb_bit_alu.sv */
`default_nettype none
module btb_bit_alu (
  btb_exec_if.alu bus
);
  // Bit test and bit set share one decoded one-hot mask
  logic [btb_pkg::DATA_W-1:0] mask;
  assign mask = btb_pkg::BIT_ONE << bus.bit_idx;
  assign bus.bit_is_set = |(bus.f_data & mask);
  assign bus.f_new = bus.f_data | mask;
endmodule
`default_nettype wire

/* verilog/btb_exec.sv */
`default_nettype none
module btb_exec (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [2:0] i_op,
  input wire logic [btb_pkg::OP_W-1:0] i_instr,
  input wire logic [btb_pkg::PC_W-1:0] i_pc,
  input wire logic [btb_pkg::DATA_W-1:0] i_wreg,
  input wire logic [btb_pkg::DATA_W-1:0] i_pc_upper_latch,
  input wire logic [btb_pkg::DATA_W-1:0] i_f_rdata,
  output logic [btb_pkg::FADDR_W-1:0] o_f_addr,
  output logic o_f_we,
  output logic [btb_pkg::DATA_W-1:0] o_f_wdata,
  output logic o_pc_load,
  output logic [btb_pkg::PC_W-1:0] o_pc_next,
  output logic o_push,
  output logic [btb_pkg::PC_W-1:0] o_stack_top,
  output logic o_flush,
  output logic o_busy,
  output logic o_watchdog_clr,
  output logic o_prescaler_clr,
  output logic o_timeout_flag_n,
  output logic o_power_down_flag_n,
  output logic o_status_we
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    btb_pkg::btb_state_t st;
    logic [btb_pkg::FADDR_W-1:0] f_addr;
    logic f_we;
    logic [btb_pkg::DATA_W-1:0] f_wdata;
    logic pc_load;
    logic [btb_pkg::PC_W-1:0] pc_next;
    logic push;
    logic [btb_pkg::PC_W-1:0] stack_top;
    logic flush;
    logic wdt_clr;
    logic to_n;
    logic pd_n;
  } btb_regs_t;

  btb_regs_t r_q;
  btb_regs_t r_d;
  btb_exec_if ebus ();
  logic [btb_pkg::PC_W-1:0] ret_pc;
  logic [btb_pkg::PC_W-1:0] br_pc;
  logic [btb_pkg::PC_W-1:0] call_pc;
  logic [btb_pkg::PC_W-1:0] call_via_wreg_op_pc;
  logic take;

  assign ebus.f_data = i_f_rdata;
  assign ebus.bit_idx = i_instr[btb_pkg::B_LSB +: btb_pkg::BIT_W];
  btb_bit_alu u_alu (.bus(ebus.alu));
  btb_pc_calc u_pc (
    .i_pc(i_pc),
    .i_wreg(i_wreg),
    .i_latch(i_pc_upper_latch),
    .i_lit(i_instr[btb_pkg::K_LSB +: btb_pkg::LIT_W]),
    .o_ret(ret_pc),
    .o_branch(br_pc),
    .o_call(call_pc),
    .o_call_via_wreg_op(call_via_wreg_op_pc)
  );

  // Read address is combinational so the read data is ready this cycle; in the
  // write cycle the held bit set address wins, so leave a gap after a bit set
  assign o_f_addr = r_q.f_we ? r_q.f_addr : i_instr[btb_pkg::F_LSB +: btb_pkg::FADDR_W];
  assign take = i_valid && (r_q.st == btb_pkg::ST_EXEC);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.f_we = 1'b0;
    r_d.pc_load = 1'b0;
    r_d.push = 1'b0;
    r_d.flush = 1'b0;
    r_d.wdt_clr = 1'b0;
    r_d.st = btb_pkg::ST_EXEC;
    if (take) begin
      unique case (i_op)
        btb_pkg::OP_SKIP_SET: begin
          if (ebus.bit_is_set) begin
            r_d.flush = 1'b1;
            r_d.st = btb_pkg::ST_FLUSH;
          end
        end
        btb_pkg::OP_BRANCH_W: begin
          r_d.pc_load = 1'b1;
          r_d.pc_next = br_pc;
          r_d.flush = 1'b1;
          r_d.st = btb_pkg::ST_FLUSH;
        end
        btb_pkg::OP_BIT_SET: begin
          r_d.f_addr = i_instr[btb_pkg::F_LSB +: btb_pkg::FADDR_W];
          r_d.f_wdata = ebus.f_new;
          r_d.f_we = 1'b1;
        end
        btb_pkg::OP_CALL: begin
          r_d.push = 1'b1;
          r_d.stack_top = ret_pc;
          r_d.pc_load = 1'b1;
          r_d.pc_next = call_pc;
          r_d.flush = 1'b1;
          r_d.st = btb_pkg::ST_FLUSH;
        end
        btb_pkg::OP_CALL_W: begin
          r_d.push = 1'b1;
          r_d.stack_top = ret_pc;
          r_d.pc_load = 1'b1;
          r_d.pc_next = call_via_wreg_op_pc;
          r_d.flush = 1'b1;
          r_d.st = btb_pkg::ST_FLUSH;
        end
        btb_pkg::OP_WDT_CLR: begin
          r_d.wdt_clr = 1'b1;
          r_d.to_n = 1'b1;
          r_d.pd_n = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_q <= '{
        st: btb_pkg::ST_EXEC,
        f_addr: '0,
        f_we: 1'b0,
        f_wdata: btb_pkg::DATA_ZERO,
        pc_load: 1'b0,
        pc_next: btb_pkg::PC_RST,
        push: 1'b0,
        stack_top: btb_pkg::PC_RST,
        flush: 1'b0,
        wdt_clr: 1'b0,
        to_n: 1'b1,
        pd_n: 1'b1
      };
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_f_we = r_q.f_we;
  assign o_f_wdata = r_q.f_wdata;
  assign o_pc_load = r_q.pc_load;
  assign o_pc_next = r_q.pc_next;
  assign o_push = r_q.push;
  assign o_stack_top = r_q.stack_top;
  // Second cycle executes a no-op in place of the fetched word
  assign o_flush = r_q.flush;
  assign o_busy = (r_q.st == btb_pkg::ST_FLUSH);
  assign o_watchdog_clr = r_q.wdt_clr;
  assign o_prescaler_clr = r_q.wdt_clr;
  assign o_timeout_flag_n = r_q.to_n;
  assign o_power_down_flag_n = r_q.pd_n;
  // Only the watchdog clear writes status; C, DC and Z are never driven here
  assign o_status_we = r_q.wdt_clr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Flush and busy stand together in the no-op cycle, then busy drops
  sequence s_two_cycle;
    o_flush && o_busy ##1 !o_busy;
  endsequence

  sequence s_flow_quiet;
    !o_pc_load && !o_push && !o_flush && !o_busy;
  endsequence

  // Nothing leaves the block after a cycle with no accepted request
  sequence s_all_quiet;
    !o_pc_load && !o_push && !o_flush && !o_f_we && !o_watchdog_clr && !o_status_we;
  endsequence

  skip_when_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_SKIP_SET && ebus.bit_is_set |=> s_two_cycle)
    else $error("skip not taken");
  no_skip_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_SKIP_SET && !ebus.bit_is_set |=> !o_flush)
    else $error("spurious skip");
  branch_target_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BRANCH_W |=>
    o_pc_load && o_pc_next == btb_pkg::PC_W'($past(i_pc) + 15'h0001 + $past(i_wreg)))
    else $error("bad branch target");
  bit_set_only_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BIT_SET |=>
    o_f_we && ((o_f_wdata ^ $past(i_f_rdata)) ==
    ((btb_pkg::BIT_ONE << $past(i_instr[btb_pkg::B_LSB +: btb_pkg::BIT_W]))
    & ~$past(i_f_rdata))))
    else $error("bit set wrong");
  call_push_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && (i_op == btb_pkg::OP_CALL || i_op == btb_pkg::OP_CALL_W) |=>
    o_push && o_stack_top == btb_pkg::PC_W'($past(i_pc) + 15'h0001))
    else $error("bad return push");
  call_target_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_CALL |=>
    o_pc_next == {$past(i_pc_upper_latch[6:3]), $past(i_instr[10:0])})
    else $error("bad call target");
  call_two_cyc_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_CALL |=> s_two_cycle)
    else $error("call not two cycles");
  call_via_wreg_op_target_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_CALL_W |=>
    o_pc_load && o_pc_next == {$past(i_pc_upper_latch[6:0]), $past(i_wreg)}
    ##0 s_two_cycle)
    else $error("bad call via w");
  wdt_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_WDT_CLR |=>
    o_watchdog_clr && o_prescaler_clr && o_timeout_flag_n && o_power_down_flag_n)
    else $error("watchdog clear incomplete");
  status_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_status_we |-> $past(take && i_op == btb_pkg::OP_WDT_CLR))
    else $error("status written unexpectedly");

  // ----------------------------------------
  // Flow checks per request class
  // ----------------------------------------
  no_skip_flow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_SKIP_SET && !ebus.bit_is_set |=>
    s_all_quiet)
    else $error("clear bit test produced output");
  skip_no_pc_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_SKIP_SET |=>
    !o_pc_load && !o_push && !o_status_we)
    else $error("skip touched pc or status");
  skip_no_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_SKIP_SET |=>
    !o_f_we && !o_watchdog_clr)
    else $error("skip wrote state");
  branch_two_cyc_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BRANCH_W |=>
    s_two_cycle)
    else $error("branch not two cycles");
  branch_no_push_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BRANCH_W |=>
    !o_push && !o_status_we)
    else $error("branch pushed or wrote status");
  branch_no_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BRANCH_W |=>
    !o_f_we && !o_watchdog_clr)
    else $error("branch wrote state");
  bit_set_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BIT_SET |=>
    o_f_addr == $past(i_instr[btb_pkg::F_LSB +: btb_pkg::FADDR_W]))
    else $error("bit set to wrong register");
  bit_set_flow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BIT_SET |=>
    s_flow_quiet)
    else $error("bit set moved program flow");
  bit_set_status_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_BIT_SET |=>
    !o_status_we && !o_watchdog_clr)
    else $error("bit set touched status");
  call_load_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_CALL |=>
    o_pc_load && o_flush)
    else $error("call did not load pc");
  call_no_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && (i_op == btb_pkg::OP_CALL || i_op == btb_pkg::OP_CALL_W) |=>
    !o_status_we && !o_f_we)
    else $error("call wrote status or file");
  call_no_clr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && (i_op == btb_pkg::OP_CALL || i_op == btb_pkg::OP_CALL_W) |=>
    !o_watchdog_clr && !o_prescaler_clr)
    else $error("call cleared watchdog");
  call_via_wreg_op_load_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_CALL_W |=>
    o_push && o_pc_load)
    else $error("call via w incomplete");
  wdt_flow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_WDT_CLR |=>
    s_flow_quiet)
    else $error("watchdog clear moved program flow");
  wdt_no_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_WDT_CLR |=>
    !o_f_we)
    else $error("watchdog clear wrote a file register");
  nop_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_op == btb_pkg::OP_NOP |=>
    s_all_quiet)
    else $error("no-op produced output");

  // ----------------------------------------
  // Pulse and hold checks
  // ----------------------------------------
  flush_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_flush |=>
    !o_flush)
    else $error("flush longer than one cycle");
  push_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_push |=>
    !o_push)
    else $error("push longer than one cycle");
  busy_refuse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_busy |=>
    s_all_quiet)
    else $error("request taken in no-op cycle");
  busy_with_flush_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_busy |->
    o_flush)
    else $error("no-op cycle without flush");
  idle_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !take |=>
    s_all_quiet)
    else $error("output without request");
  prescaler_pair_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_watchdog_clr |->
    o_prescaler_clr)
    else $error("prescaler not cleared");
  prescaler_only_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_prescaler_clr |->
    o_watchdog_clr)
    else $error("prescaler cleared alone");
  stack_held_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_push |->
    $stable(o_stack_top))
    else $error("return address moved without push");
  pc_next_held_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_pc_load |->
    $stable(o_pc_next))
    else $error("pc target moved without load");
  wdata_held_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_f_we |->
    $stable(o_f_wdata))
    else $error("write data moved without write");
  f_addr_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_f_we |->
    o_f_addr == i_instr[btb_pkg::F_LSB +: btb_pkg::FADDR_W])
    else $error("read address not from instruction");
endmodule
`default_nettype wire

/* verilog/btb_exec_if.sv */
`default_nettype none
interface btb_exec_if;
  logic [btb_pkg::DATA_W-1:0] f_data;
  logic [btb_pkg::BIT_W-1:0] bit_idx;
  logic bit_is_set;
  logic [btb_pkg::DATA_W-1:0] f_new;
  modport dec (output f_data, output bit_idx, input bit_is_set, input f_new);
  modport alu (input f_data, input bit_idx, output bit_is_set, output f_new);
endinterface
`default_nettype wire

/* verilog/btb_pc_calc.sv */
`default_nettype none
module btb_pc_calc (
  input wire logic [btb_pkg::PC_W-1:0] i_pc,
  input wire logic [btb_pkg::DATA_W-1:0] i_wreg,
  input wire logic [btb_pkg::DATA_W-1:0] i_latch,
  input wire logic [btb_pkg::LIT_W-1:0] i_lit,
  output logic [btb_pkg::PC_W-1:0] o_ret,
  output logic [btb_pkg::PC_W-1:0] o_branch,
  output logic [btb_pkg::PC_W-1:0] o_call,
  output logic [btb_pkg::PC_W-1:0] o_call_via_wreg_op
);
  localparam int UPW = btb_pkg::PC_W - btb_pkg::LIT_W;
  localparam int UPW2 = btb_pkg::PC_W - btb_pkg::PC_LOW_W;
  assign o_ret = btb_pkg::PC_W'(i_pc + btb_pkg::PC_ONE);
  // Unsigned add, wraps at the top of program space
  assign o_branch = btb_pkg::PC_W'(o_ret + {{(btb_pkg::PC_W-btb_pkg::DATA_W){1'b0}}, i_wreg});
  assign o_call = {i_latch[btb_pkg::LATCH_CALL_LSB +: UPW], i_lit};
  assign o_call_via_wreg_op = {i_latch[btb_pkg::LATCH_CALL_VIA_WREG_OP_MSB -: UPW2], i_wreg};
endmodule
`default_nettype wire

/* verilog/btb_pkg.sv */
`default_nettype none
package btb_pkg;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int OP_W = 14;
  localparam int LIT_W = 11;
  // Opcode class encodings of the executed instruction
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_SKIP_SET = 3'h1;
  localparam logic [2:0] OP_BRANCH_W = 3'h2;
  localparam logic [2:0] OP_BIT_SET = 3'h3;
  localparam logic [2:0] OP_CALL = 3'h4;
  localparam logic [2:0] OP_CALL_W = 3'h5;
  localparam logic [2:0] OP_WDT_CLR = 3'h6;
  // Field positions in the 14-bit instruction word
  localparam int F_LSB = 0;
  localparam int B_LSB = 7;
  localparam int K_LSB = 0;
  localparam int LATCH_CALL_LSB = 3;
  localparam int LATCH_CALL_VIA_WREG_OP_MSB = 6;
  localparam int PC_LOW_W = 8;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_FLUSH = 3'b010,
    ST_IDLE = 3'b100
  } btb_state_t;
endpackage
`default_nettype wire
